// file: ssx_exec.sv
// Purpose: apb-driven executor for subtract, swap, xor and direction load
// Assumes: apb master with setup and access phases, one transfer at a time
// Notes:   a write to the command register runs one instruction
//
// What this block does
// RULE_01: sub: file minus accumulator, dest bit routes
// RULE_02: sub sets carry, half carry, zero
// RULE_03: borrow subtract also removes inverted carry
// RULE_04: swap nibbles, route result, flags kept
// RULE_05: xor literal into accumulator, zero only
// RULE_06: xor file, dest bit routes, zero only
// RULE_07: accumulator loads direction register 5..7
// RULE_08: zero flag set when result is zero
`timescale 1ns/10ps
module ssx_exec (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic      [ssx_pkg::DATA_W-1:0] port_a_dir_reg,
    output logic      [ssx_pkg::DATA_W-1:0] port_b_dir_reg,
    output logic      [ssx_pkg::DATA_W-1:0] port_c_dir_reg
);
    import ssx_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ssx_state_t        state,    next_state;
    ssx_op_t           cmd_op,   next_cmd_op;
    logic              cmd_dest, next_cmd_dest;
    logic [ADDR_W-1:0] cmd_addr, next_cmd_addr;
    logic [DATA_W-1:0] cmd_lit,  next_cmd_lit;
    logic [DATA_W-1:0] acc,      next_acc;
    logic              c_flag,   next_c_flag;
    logic              half_carry_flag, next_half_carry_flag;
    logic              z_flag,   next_z_flag;
    logic [ADDR_W-1:0] faddr,    next_faddr;
    logic [DATA_W-1:0] next_dir_a, next_dir_b, next_dir_c;
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;

    logic              acc_phase;
    logic              accept;
    logic              mapped;
    logic              ram_we;
    logic [ADDR_W-1:0] ram_waddr;
    logic [DATA_W-1:0] ram_wdata;
    logic [DATA_W-1:0] fval;
    logic [DATA_W-1:0] win_data;
    logic              exec_go;

    // ----------------------------------------------------------------
    // datapath pieces
    // ----------------------------------------------------------------
    ssx_alu_if u_if ();

    ssx_alu u_alu (
        .bus (u_if.alu)
    );

    ssx_file_ram #(
        .AW (ADDR_W),
        .DW (DATA_W)
    ) u_ram (
        .clk     (pclk),
        .we      (ram_we),
        .waddr   (ram_waddr),
        .wdata   (ram_wdata),
        .raddr_a (cmd_addr),
        .rdata_a (fval),
        .raddr_b (faddr),
        .rdata_b (win_data)
    );

    // alu operands
    assign u_if.op   = cmd_op;
    assign u_if.acc  = acc;
    assign u_if.fval = fval;
    assign u_if.lit  = cmd_lit;
    assign u_if.cin  = (cmd_op == sub_with_borrow_op) ? c_flag : 1'b1;  // [RULE_03]

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign acc_phase = psel & penable;
    assign accept    = acc_phase & pready;
    assign exec_go   = (state == st_exec);
    assign mapped    = (paddr[1:0] == 2'h0) && (paddr <= OFS_DIRC);

    // ----------------------------------------------------------------
    // next values: bus, sequencer, execute writeback
    // ----------------------------------------------------------------
    always_comb begin
        next_state           = state;
        next_cmd_op          = cmd_op;
        next_cmd_dest        = cmd_dest;
        next_cmd_addr        = cmd_addr;
        next_cmd_lit         = cmd_lit;
        next_acc             = acc;
        next_c_flag          = c_flag;
        next_half_carry_flag = half_carry_flag;
        next_z_flag          = z_flag;
        next_faddr           = faddr;
        next_dir_a           = port_a_dir_reg;
        next_dir_b           = port_b_dir_reg;
        next_dir_c           = port_c_dir_reg;
        next_pready          = acc_phase & ~pready;  // one wait state
        next_prdata          = prdata;
        next_pslverr         = 1'b0;
        ram_we               = 1'b0;
        ram_waddr            = faddr;
        ram_wdata            = pwdata[DATA_W-1:0];

        // read data and error settle during the wait state
        if (acc_phase && !pready) begin
            next_pslverr = ~mapped;
            case (paddr)
                OFS_CMD:    next_prdata = {8'h00, cmd_lit, 5'h00, cmd_addr,
                                           cmd_dest, cmd_op};
                OFS_ACC:    next_prdata = {24'h0, acc};
                OFS_STATUS: next_prdata = {28'h0, exec_go, z_flag,
                                           half_carry_flag, c_flag};
                OFS_FADDR:  next_prdata = {25'h0, faddr};
                OFS_FDATA:  next_prdata = {24'h0, win_data};
                OFS_DIRA:   next_prdata = {24'h0, port_a_dir_reg};
                OFS_DIRB:   next_prdata = {24'h0, port_b_dir_reg};
                OFS_DIRC:   next_prdata = {24'h0, port_c_dir_reg};
                default:    next_prdata = 32'h0;
            endcase
        end

        // writes take effect at the completing edge
        if (accept && pwrite && mapped) begin
            case (paddr)
                OFS_CMD: begin
                    if (!exec_go) begin
                        next_cmd_op   = ssx_op_t'(pwdata[CMD_OP_LSB +: 3]);
                        next_cmd_dest = pwdata[CMD_DEST_BIT];
                        next_cmd_addr = pwdata[CMD_ADDR_LSB +: ADDR_W];
                        next_cmd_lit  = pwdata[CMD_LIT_LSB +: DATA_W];
                        next_state    = st_exec;
                    end
                end
                OFS_ACC:    next_acc   = pwdata[DATA_W-1:0];
                OFS_STATUS: begin
                    next_c_flag          = pwdata[STAT_C];
                    next_half_carry_flag = pwdata[STAT_DC];
                    next_z_flag          = pwdata[STAT_Z];
                end
                OFS_FADDR:  next_faddr = pwdata[ADDR_W-1:0];
                OFS_FDATA:  ram_we     = 1'b1;
                default:    ;
            endcase
        end

        // execute cycle
        case (state)
            st_idle: ;
            st_exec: begin
                next_state = st_idle;
                ram_waddr  = cmd_addr;
                ram_wdata  = u_if.result;
                case (cmd_op)
                    sub_acc_from_file_op, sub_with_borrow_op: begin
                        if (cmd_dest) ram_we = 1'b1;                 // [RULE_01] [RULE_03]
                        else          next_acc = u_if.result;        // [RULE_01] [RULE_03]
                        next_c_flag          = u_if.c_out;           // [RULE_02] [RULE_03]
                        next_half_carry_flag = u_if.dc_out;          // [RULE_02]
                        next_z_flag          = (u_if.result == 8'h00); // [RULE_08]
                    end
                    nibble_exchange_op: begin
                        if (cmd_dest) ram_we = 1'b1;                 // [RULE_04]
                        else          next_acc = u_if.result;        // [RULE_04]
                    end
                    xor_immediate_op: begin
                        next_acc    = u_if.result;                   // [RULE_05]
                        next_z_flag = (u_if.result == 8'h00);        // [RULE_05] [RULE_08]
                    end
                    xor_file_op: begin
                        if (cmd_dest) ram_we = 1'b1;                 // [RULE_06]
                        else          next_acc = u_if.result;        // [RULE_06]
                        next_z_flag = (u_if.result == 8'h00);        // [RULE_06] [RULE_08]
                    end
                    port_dir_load_op: begin
                        case (cmd_addr)
                            SEL_DIRA: next_dir_a = acc;              // [RULE_07]
                            SEL_DIRB: next_dir_b = acc;              // [RULE_07]
                            SEL_DIRC: next_dir_c = acc;              // [RULE_07]
                            default:  ;
                        endcase
                    end
                    default: ;
                endcase
            end
            default: next_state = st_idle;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state           <= st_idle;
            cmd_op          <= no_op;
            cmd_dest        <= 1'b0;
            cmd_addr        <= '0;
            cmd_lit         <= '0;
            acc             <= ACC_RST;
            c_flag          <= FLAG_RST[STAT_C];
            half_carry_flag <= FLAG_RST[STAT_DC];
            z_flag          <= FLAG_RST[STAT_Z];
            faddr           <= '0;
            port_a_dir_reg  <= DIR_RST;
            port_b_dir_reg  <= DIR_RST;
            port_c_dir_reg  <= DIR_RST;
            prdata          <= 32'h0;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
        end else begin
            state           <= next_state;
            cmd_op          <= next_cmd_op;
            cmd_dest        <= next_cmd_dest;
            cmd_addr        <= next_cmd_addr;
            cmd_lit         <= next_cmd_lit;
            acc             <= next_acc;
            c_flag          <= next_c_flag;
            half_carry_flag <= next_half_carry_flag;
            z_flag          <= next_z_flag;
            faddr           <= next_faddr;
            port_a_dir_reg  <= next_dir_a;
            port_b_dir_reg  <= next_dir_b;
            port_c_dir_reg  <= next_dir_c;
            prdata          <= next_prdata;
            pready          <= next_pready;
            pslverr         <= next_pslverr;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic is_sub;
    assign is_sub = exec_go && (cmd_op == sub_acc_from_file_op);

    property p_sub_value;
        is_sub |-> u_if.result == DATA_W'(fval - acc);
    endproperty
    a_sub_value: assert property (p_sub_value) else $error("sub result wrong"); // [RULE_01]

    property p_sub_to_acc;
        is_sub && !cmd_dest |=> acc == $past(u_if.result);
    endproperty
    a_sub_to_acc: assert property (p_sub_to_acc) else $error("sub not in acc"); // [RULE_01]

    property p_sub_flags;
        is_sub |=> c_flag == ($past(acc) <= $past(fval))
               && half_carry_flag == ($past(acc[3:0]) <= $past(fval[3:0]));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("sub flags wrong"); // [RULE_02]

    property p_subb_value;
        exec_go && cmd_op == sub_with_borrow_op
            |-> u_if.result == DATA_W'(fval - acc - {7'h0, ~c_flag});
    endproperty
    a_subb_value: assert property (p_subb_value) else $error("borrow sub wrong"); // [RULE_03]

    property p_swap_keeps_flags;
        exec_go && cmd_op == nibble_exchange_op
            |-> u_if.result == {fval[3:0], fval[7:4]}
            ##1 $stable({c_flag, half_carry_flag, z_flag});
    endproperty
    a_swap_keeps_flags: assert property (p_swap_keeps_flags) else $error("swap bad"); // [RULE_04]

    property p_xorl;
        exec_go && cmd_op == xor_immediate_op
            |=> acc == ($past(u_if.acc) ^ $past(cmd_lit))
                && $stable({c_flag, half_carry_flag});
    endproperty
    a_xorl: assert property (p_xorl) else $error("xor literal bad"); // [RULE_05]

    property p_xorf_file;
        exec_go && cmd_op == xor_file_op && cmd_dest
            |-> ram_we && ram_waddr == cmd_addr && ram_wdata == (acc ^ fval);
    endproperty
    a_xorf_file: assert property (p_xorf_file) else $error("xor file bad"); // [RULE_06]

    property p_dir_b;
        exec_go && cmd_op == port_dir_load_op && cmd_addr == SEL_DIRB
            |=> port_b_dir_reg == $past(acc) && $stable(port_a_dir_reg);
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("direction load bad"); // [RULE_07]

    property p_zero;
        exec_go && cmd_op inside {sub_acc_from_file_op, xor_file_op}
            |=> z_flag == ($past(u_if.result) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag bad"); // [RULE_08]

    // main scenarios
    c_sub_zero: cover property (is_sub && u_if.result == 8'h00);
    c_borrow:   cover property (exec_go && cmd_op == sub_with_borrow_op && !c_flag);
    c_dir_c:    cover property (exec_go && cmd_op == port_dir_load_op && cmd_addr == SEL_DIRC);
    c_xor_file: cover property (exec_go && cmd_op == xor_file_op && cmd_dest);

endmodule : ssx_exec

// file: ssx_pkg.sv
// Purpose: shared constants and types of the subtract/swap/xor executor
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   all offsets, field positions and reset values live here
package ssx_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;   // accumulator and file register width
    localparam int ADDR_W = 7;   // file operand field, 0..127

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CMD    = 8'h00;  // write issues an instruction
    localparam logic [7:0] OFS_ACC    = 8'h04;  // accumulator
    localparam logic [7:0] OFS_STATUS = 8'h08;  // flags and busy
    localparam logic [7:0] OFS_FADDR  = 8'h0c;  // file window pointer
    localparam logic [7:0] OFS_FDATA  = 8'h10;  // file window data
    localparam logic [7:0] OFS_DIRA   = 8'h14;  // port a direction, read only
    localparam logic [7:0] OFS_DIRB   = 8'h18;  // port b direction, read only
    localparam logic [7:0] OFS_DIRC   = 8'h1c;  // port c direction, read only

    // ----------------------------------------------------------------
    // command register fields
    // ----------------------------------------------------------------
    localparam int CMD_OP_LSB   = 0;    // 3-bit opcode
    localparam int CMD_DEST_BIT = 3;    // 0 accumulator, 1 file register
    localparam int CMD_ADDR_LSB = 4;    // 7-bit file operand
    localparam int CMD_LIT_LSB  = 16;   // 8-bit literal

    // ----------------------------------------------------------------
    // status register fields
    // ----------------------------------------------------------------
    localparam int STAT_C    = 0;
    localparam int STAT_DC   = 1;
    localparam int STAT_Z    = 2;
    localparam int STAT_BUSY = 3;

    // ----------------------------------------------------------------
    // reset values and direction selectors
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
    localparam logic [2:0]        FLAG_RST = 3'h0;   // c, dc, z
    localparam logic [DATA_W-1:0] DIR_RST  = 8'hff;  // all pins input
    localparam logic [ADDR_W-1:0] SEL_DIRA = 7'h05;
    localparam logic [ADDR_W-1:0] SEL_DIRB = 7'h06;
    localparam logic [ADDR_W-1:0] SEL_DIRC = 7'h07;

    // ----------------------------------------------------------------
    // opcodes and sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        no_op                = 3'b000,
        sub_acc_from_file_op = 3'b001,
        sub_with_borrow_op   = 3'b010,
        nibble_exchange_op   = 3'b011,
        xor_immediate_op     = 3'b100,
        xor_file_op          = 3'b101,
        port_dir_load_op     = 3'b110
    } ssx_op_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_exec = 2'b01
    } ssx_state_t;

endpackage : ssx_pkg

// file: ssx_alu_if.sv
// Purpose: operand and result bundle between sequencer and alu
// Assumes: purely combinational traffic
// Notes:   top drives operands, alu drives results
`timescale 1ns/10ps
interface ssx_alu_if;
    import ssx_pkg::*;
    ssx_op_t           op;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] fval;
    logic [DATA_W-1:0] lit;
    logic              cin;
    logic [DATA_W-1:0] result;
    logic              c_out;
    logic              dc_out;

    modport top (output op, acc, fval, lit, cin, input result, c_out, dc_out);
    modport alu (input op, acc, fval, lit, cin, output result, c_out, dc_out);
endinterface : ssx_alu_if

// file: ssx_alu.sv
// Purpose: result and carries for the executed instruction
// Assumes: operands stable for the execute cycle
// Notes:   subtraction done as f + ~w + cin
`timescale 1ns/10ps
module ssx_alu (
    ssx_alu_if.alu bus
);
    import ssx_pkg::*;

    // ----------------------------------------------------------------
    // adder shared by byte and nibble carries
    // ----------------------------------------------------------------
    function automatic logic [DATA_W:0] add_c(input logic [DATA_W-1:0] a,
                                             input logic [DATA_W-1:0] b,
                                             input logic              ci);
        add_c = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, ci};
    endfunction : add_c

    logic [DATA_W:0] full_sum;
    logic [DATA_W:0] nib_sum;

    // carry out means no borrow
    assign full_sum = add_c(bus.fval, ~bus.acc, bus.cin);
    assign nib_sum  = add_c({4'h0, bus.fval[3:0]}, {4'h0, ~bus.acc[3:0]}, bus.cin);

    // result by opcode
    always_comb begin
        bus.c_out  = full_sum[DATA_W];
        bus.dc_out = nib_sum[4];
        case (bus.op)
            sub_acc_from_file_op: bus.result = full_sum[DATA_W-1:0];
            sub_with_borrow_op:   bus.result = full_sum[DATA_W-1:0];
            nibble_exchange_op:   bus.result = {bus.fval[3:0], bus.fval[7:4]};
            xor_immediate_op:     bus.result = bus.acc ^ bus.lit;
            xor_file_op:          bus.result = bus.acc ^ bus.fval;
            default:              bus.result = bus.acc;
        endcase
    end

endmodule : ssx_alu

// file: ssx_file_ram.sv
// Purpose: file register array, one write and two read ports
// Assumes: single writer per cycle
// Notes:   contents undefined after reset
`timescale 1ns/10ps
module ssx_file_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr_a,
    output logic      [DW-1:0] rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [DW-1:0] rdata_b
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // asynchronous reads
    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

    // synchronous write
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

endmodule : ssx_file_ram

// file: ssx_exec_tb.sv
// Purpose: self-checking bench of the subtract/swap/xor executor over apb
// Assumes: one wait state per transfer, command done before next transfer
// Notes:   reads queue their expected word, a monitor pops at each pready
`timescale 1ns/10ps
module ssx_exec_tb;
    import ssx_pkg::*;
    logic              pclk    = 1'b0;
    logic              presetn = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [7:0]        paddr   = 8'h00;
    logic [31:0]       pwdata  = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] dir_a, dir_b, dir_c;
    logic [32:0]       exp_q[$];
    logic [32:0]       e;
    logic [7:0]        m_acc   = 8'h00;
    logic [2:0]        m_flg   = 3'h0;   // z, dc, c
    logic [7:0]        m_dir[3];
    int                errors  = 0;
    int                n_compared = 0;
    int                seed_v;
    ssx_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_a_dir_reg(dir_a), .port_b_dir_reg(dir_b),
        .port_c_dir_reg(dir_c));
    always #20 pclk = ~pclk;
    // -----------------------------------------------------------------
    // tasks
    // -----------------------------------------------------------------
    task automatic end_of_test;
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] ex);
        int n;
        n = 0;
        @(posedge pclk);
        exp_q.push_back(ex);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            $display("[ERR] apb pready exp 1 got %b", pready);
            errors++;
            end_of_test();
        end else begin
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 33'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        apb(1'b0, a, 32'h0, {25'h0, ex});
    endtask : rd
    // direct look at a direction port
    task automatic chk8(input logic [7:0] got, input logic [7:0] ex);
        n_compared++;
        if (got !== ex) begin
            $display("[ERR] dir port exp %h got %h", ex, got);
            errors++;
        end
    endtask : chk8
    // load operands, run one instruction, predict and read back results
    task automatic run(input ssx_op_t op, input logic dest, input logic [6:0] a,
                       input logic [7:0] f, input logic [7:0] lit);
        logic       bw;
        logic       c;
        logic       dc;
        logic [7:0] r;
        wr(OFS_FADDR, {1'b0, a}); wr(OFS_FDATA, f);
        wr(OFS_ACC, m_acc); wr(OFS_STATUS, {5'h0, m_flg});
        wr(OFS_CMD, 8'h00);
        apb(1'b1, OFS_CMD, {8'h0, lit, 5'h0, a, dest, op}, 33'h0);
        // borrow in is the inverted carry, only for the borrow subtract
        bw = (op == sub_with_borrow_op) ? ~m_flg[0] : 1'b0;
        c  = ({1'b0, m_acc} + 9'(bw)) <= {1'b0, f};
        dc = ({1'b0, m_acc[3:0]} + 5'(bw)) <= {1'b0, f[3:0]};
        case (op)
            sub_acc_from_file_op, sub_with_borrow_op: begin
                r     = f - m_acc - 8'(bw);
                m_flg = {r == 8'h00, dc, c};
            end
            nibble_exchange_op: r = {f[3:0], f[7:4]};
            xor_immediate_op: begin
                r        = m_acc ^ lit;
                m_flg[2] = (r == 8'h00);
            end
            default: begin
                r        = m_acc ^ f;
                m_flg[2] = (r == 8'h00);
            end
        endcase
        if (dest && op != xor_immediate_op) f = r;
        else m_acc = r;
        rd(OFS_ACC, m_acc); rd(OFS_STATUS, {5'h0, m_flg}); rd(OFS_FDATA, f);
    endtask : run
    // -----------------------------------------------------------------
    // monitor: oldest note against each completed transfer
    // -----------------------------------------------------------------
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            n_compared++;
            if (pslverr !== e[32] || (!pwrite && prdata !== e[31:0])) begin
                $display("[ERR] apb addr %h exp %h got %h", paddr, e, {pslverr, prdata});
                errors++;
            end
        end
    end
    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        seed_v = $urandom(32'he188c3b7);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_ACC, ACC_RST); rd(OFS_STATUS, {5'h0, FLAG_RST});
        rd(OFS_DIRA, DIR_RST); rd(OFS_DIRB, DIR_RST); rd(OFS_DIRC, DIR_RST);
        wr(OFS_DIRA, 8'h00); rd(OFS_DIRA, DIR_RST);
        apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 8'h02, 32'h5a, {1'b1, 32'h0});
        // borrow and zero corners with both carry states
        for (int k = 0; k < 4; k++) begin
            for (int o = 1; o <= 2; o++) begin
                m_acc = (k == 0) ? 8'h10 : (k == 1) ? 8'h01 : (k == 2) ? 8'h0f : 8'h00;
                m_flg = 3'(k);
                run(ssx_op_t'(3'(o)), 1'(k), 7'(k + 9), (k < 2) ? 8'h10 - 8'(k) : 8'h10, 8'h00);
            end
        end
        m_acc = 8'h5a;
        run(xor_immediate_op, 1'b1, 7'h11, 8'h33, 8'h5a);
        run(xor_file_op, 1'b1, 7'h7f, 8'h00, 8'h00);
        repeat (60) begin
            m_acc = 8'($urandom);
            m_flg = 3'($urandom);
            run(ssx_op_t'(3'($urandom_range(1, 5))), 1'($urandom), 7'($urandom), 8'($urandom), 8'($urandom));
        end
        // direction loads, operand 8 loads nothing
        m_dir = '{DIR_RST, DIR_RST, DIR_RST};
        for (int s = 5; s <= 8; s++) begin
            m_acc = 8'($urandom);
            if (s < 8) m_dir[s-5] = m_acc;
            m_flg = 3'($urandom);
            wr(OFS_ACC, m_acc); wr(OFS_STATUS, {5'h0, m_flg});
            apb(1'b1, OFS_CMD, {21'h0, 7'(s), 1'b0, 3'(port_dir_load_op)}, 33'h0);
            rd(OFS_DIRA, m_dir[0]); rd(OFS_DIRB, m_dir[1]); rd(OFS_DIRC, m_dir[2]);
            rd(OFS_STATUS, {5'h0, m_flg}); rd(OFS_ACC, m_acc);
            chk8(dir_a, m_dir[0]); chk8(dir_b, m_dir[1]); chk8(dir_c, m_dir[2]);
        end
        end_of_test();
    end
endmodule : ssx_exec_tb
